// [verilog/smux_pkg.sv]
package smux_pkg;

   // ------------------------------------------------------------------
   // hardware modes and pin owners
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_VGA,
      MODE_ACCEL64,
      MODE_ACCEL32_ROM,
      MODE_ACCEL32_PIX
   } smux_mode_e;

   typedef enum logic [1:0] {
      OWN_MEM,
      OWN_ROM,
      OWN_PERIPH
   } smux_own_e;

   localparam smux_mode_e MODE_AFTER_RESET = MODE_VGA;

   // ------------------------------------------------------------------
   // widths and timing
   // ------------------------------------------------------------------
   localparam int DATA_W = 64;
   localparam int CTRL_W = 22;
   localparam int CLK_PERIOD_NS = 5;
   localparam int PERIPH_ACCESS_NS = 300;
   localparam int PERIPH_CYC =
      (PERIPH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ROM_CYC_DEFAULT = 12;
   localparam logic [7:0] CNT_ZERO = 8'h00;

   // ------------------------------------------------------------------
   // shared data pin positions
   // ------------------------------------------------------------------
   localparam int PA_LO = 0;
   localparam int PA_HI = 16;
   localparam int PD_LO = 18;
   localparam int PD_HI = 25;
   localparam int P_RD_PIN = 26;
   localparam int P_WR_PIN = 27;
   localparam int RA_LO = 32;
   localparam int RA_HI = 49;
   localparam int RD_LO = 50;
   localparam int RD_HI = 57;
   localparam int R_WE_PIN = 58;
   localparam int FEAT_LO = 59;
   localparam int PIX_LO = 51;
   localparam int STRAP_STB_BIT = 8;
   localparam int STRAP_SEL_BIT = 9;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] cas_n;
      logic [2:0] ras_n;
      logic oe_n;
      logic we_n;
   } smux_dram_s;

   localparam smux_dram_s DRAM_IDLE = '{9'h000, 8'hFF, 3'h7, 1'b1, 1'b1};

   typedef struct packed {
      logic valid;
      logic write;
      logic sparse;
      logic [17:0] addr;
      logic [7:0] wdata;
   } smux_rom_req_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [16:0] addr;
      logic [7:0] wdata;
   } smux_periph_req_s;

   typedef struct packed {
      logic done;
      logic refused;
      logic [15:0] rdata;
   } smux_ans_s;

   localparam smux_ans_s ANS_IDLE = '{1'b0, 1'b0, 16'h0000};

endpackage

// [verilog/smux_shared_pin_mux.sv]
// What this block does
// - 64 data pins shared by all users, plus 22 dram control lines for memory
// - reset leaves VGA mode: feature out, rom, low-half frame buffer
// - VGA mode never runs peripheral or 16-bit pixel cycles
// - VGA pinout: memory low 32, feature 63:59 and low pins, rom 58:32
// - accel 64-bit: rom and peripheral allowed, no feature or pixel out
// - accel 32-bit: peripheral with either pixel or rom, never both
// - peripheral cycle: address 16:0, data 25:18, read 26, write 27
// - accel 32-bit rom mode: memory 31:0, rom on 58:32, 63:59 unused
// - accel 64-bit: memory all 64 pins, rom and peripheral time-share
// - 32-bit pixel mode: pixel 3..15 on 63:51, 2..0 on low pins
// - connector bits on data pins run opposite to pin numbering
// - dram pins only for memory, rom enable rom, select peripheral
// - strap select and strobe pin levels sampled while reset is held
// - sparse rom reads return select strap bit 9, strobe strap bit 8
// - vga and accel memory controllers muxed right before the pins
// - peripheral accesses wait for the pins behind rom cycles, not memory
// - every peripheral cycle lasts a fixed 300 ns
module smux_shared_pin_mux #(
   parameter int ROM_CYC = smux_pkg::ROM_CYC_DEFAULT
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic mode_load_i,
   input wire smux_pkg::smux_mode_e mode_sel_i,
   output smux_pkg::smux_mode_e mode_o,
   input wire smux_pkg::smux_dram_s vga_dram_i,
   input wire logic [31:0] vga_wdata_i,
   input wire logic vga_wdrive_i,
   input wire smux_pkg::smux_dram_s accel_dram_i,
   input wire logic [63:0] accel_wdata_i,
   input wire logic accel_wdrive_i,
   output logic mem_grant_o,
   input wire logic [15:0] pix_i,
   input wire logic pix_valid_i,
   input wire smux_pkg::smux_rom_req_s rom_req_i,
   output smux_pkg::smux_ans_s rom_ans_o,
   input wire smux_pkg::smux_periph_req_s periph_req_i,
   output smux_pkg::smux_ans_s periph_ans_o,
   input wire logic [63:0] memdata_i,
   output logic [63:0] memdata_o,
   output logic [63:0] memdata_oe_n_o,
   output logic [2:0] feat_low_o,
   output logic feat_low_oe_n_o,
   output smux_pkg::smux_dram_s dram_o,
   output logic rom_ce_n_o,
   input wire logic periph_select_n_i,
   output logic periph_select_n_o,
   output logic periph_select_n_oe_n_o,
   input wire logic periph_strobe_n_i,
   output logic periph_strobe_n_o,
   output logic periph_strobe_n_oe_n_o
);
   import smux_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   smux_mode_e mode_q;
   smux_own_e own_q, own_d;
   logic [7:0] cnt_q, cnt_d;
   smux_rom_req_s rom_q;
   smux_periph_req_s per_q;
   logic [1:0] strap_q;
   logic in_reset_q;
   smux_ans_s rom_ans_q, rom_ans_d, per_ans_q, per_ans_d;
   logic [63:0] data_q, data_d, oe_n_q, oe_n_d;
   logic [2:0] feat_q;
   logic feat_oe_n_q;
   smux_dram_s dram_q, dram_d;
   logic rom_ce_n_q, sel_n_q, stb_n_q;

   // ------------------------------------------------------------------
   // mode permissions
   // ------------------------------------------------------------------
   wire rom_ok = (mode_q != MODE_ACCEL32_PIX);
   wire per_ok = (mode_q != MODE_VGA);
   wire feat8_on = (mode_q == MODE_VGA) && pix_valid_i;
   wire pix16_on = (mode_q == MODE_ACCEL32_PIX) && pix_valid_i;
   wire idle = (own_q == OWN_MEM);
   wire cnt_end = (cnt_q == CNT_ZERO);
   wire rom_take = idle && rom_req_i.valid && rom_ok;
   // rom wins a tie: boot reads are rare and short
   wire per_take = idle && periph_req_i.valid && per_ok && !rom_take;
   wire rom_refuse = idle && rom_req_i.valid && !rom_ok;
   wire per_refuse = idle && periph_req_i.valid && !per_ok;
   wire ld_mode = idle && mode_load_i && !rom_take && !per_take;

   // ------------------------------------------------------------------
   // connector bit reversal on the shared data pins
   // ------------------------------------------------------------------
   logic [4:0] feat_hi;
   logic [12:0] pix_hi;
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_feat
         assign feat_hi[gi] = pix_i[7 - gi];
      end
      for (gi = 0; gi < 13; gi++) begin : g_pix
         assign pix_hi[gi] = pix_i[15 - gi];
      end
   endgenerate

   // ------------------------------------------------------------------
   // ownership sequencer; a started cycle always runs to its end
   // ------------------------------------------------------------------
   always_comb begin
      own_d = own_q;
      cnt_d = cnt_q;
      if (rom_take) begin
         own_d = OWN_ROM;
         cnt_d = 8'(ROM_CYC - 1);
      end else if (per_take) begin
         own_d = OWN_PERIPH;
         cnt_d = 8'(PERIPH_CYC - 1);
      end else if (!idle) begin
         if (cnt_end) begin
            own_d = OWN_MEM;
         end else begin
            cnt_d = cnt_q - 8'h01;
         end
      end
   end

   // answers: read data taken from the pins in the last cycle
   always_comb begin
      rom_ans_d = ANS_IDLE;
      per_ans_d = ANS_IDLE;
      rom_ans_d.refused = rom_refuse;
      per_ans_d.refused = per_refuse;
      if (own_q == OWN_ROM && cnt_end) begin
         rom_ans_d.done = 1'b1;
         rom_ans_d.rdata[7:0] = memdata_i[RD_HI:RD_LO];
         if (rom_q.sparse) begin
            rom_ans_d.rdata[STRAP_SEL_BIT] = strap_q[1];
            rom_ans_d.rdata[STRAP_STB_BIT] = strap_q[0];
         end
      end
      if (own_q == OWN_PERIPH && cnt_end) begin
         per_ans_d.done = 1'b1;
         per_ans_d.rdata[7:0] = memdata_i[PD_HI:PD_LO];
      end
   end

   // ------------------------------------------------------------------
   // pin composition, one owner at a time
   // ------------------------------------------------------------------
   always_comb begin
      data_d = 64'h0000000000000000;
      oe_n_d = 64'hFFFFFFFFFFFFFFFF;
      dram_d = DRAM_IDLE;
      case (own_q)
         OWN_MEM: begin
            // memory controllers muxed at the pins
            if (mode_q == MODE_VGA) begin
               dram_d = vga_dram_i;
               data_d[31:0] = vga_wdata_i;
               oe_n_d[31:0] = {32{!vga_wdrive_i}};
            end else if (mode_q == MODE_ACCEL64) begin
               dram_d = accel_dram_i;
               data_d = accel_wdata_i;
               oe_n_d = {64{!accel_wdrive_i}};
            end else begin
               dram_d = accel_dram_i;
               data_d[31:0] = accel_wdata_i[31:0];
               oe_n_d[31:0] = {32{!accel_wdrive_i}};
            end
         end
         OWN_ROM: begin
            data_d[RA_HI:RA_LO] = rom_q.addr;
            oe_n_d[RA_HI:RA_LO] = 18'h00000;
            data_d[RD_HI:RD_LO] = rom_q.wdata;
            oe_n_d[RD_HI:RD_LO] = {8{!rom_q.write}};
            data_d[R_WE_PIN] = !(rom_q.write && cnt_q != CNT_ZERO);
            oe_n_d[R_WE_PIN] = 1'b0;
         end
         OWN_PERIPH: begin
            data_d[PA_HI:PA_LO] = per_q.addr;
            oe_n_d[PA_HI:PA_LO] = 17'h00000;
            data_d[PD_HI:PD_LO] = per_q.wdata;
            oe_n_d[PD_HI:PD_LO] = {8{!per_q.write}};
            data_d[P_RD_PIN] = per_q.write;
            data_d[P_WR_PIN] = !per_q.write;
            oe_n_d[P_WR_PIN:P_RD_PIN] = 2'b00;
         end
         default: begin
            dram_d = DRAM_IDLE;
         end
      endcase
      // connector pins never overlap the active owner's pins
      if (feat8_on) begin
         data_d[63:FEAT_LO] = feat_hi;
         oe_n_d[63:FEAT_LO] = 5'h00;
      end
      if (pix16_on) begin
         data_d[63:PIX_LO] = pix_hi;
         oe_n_d[63:PIX_LO] = 13'h0000;
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // mode only changes between owned cycles
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         mode_q <= MODE_AFTER_RESET;
      end else if (ld_mode) begin
         mode_q <= mode_sel_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         own_q <= OWN_MEM;
         cnt_q <= CNT_ZERO;
      end else begin
         own_q <= own_d;
         cnt_q <= cnt_d;
      end
   end

   // request latches, held for the whole cycle
   always_ff @(posedge clock_i) begin
      if (rom_take) rom_q <= rom_req_i;
      if (per_take) per_q <= periph_req_i;
   end

   // straps follow the pins while reset is held, freeze on release
   always_ff @(posedge clock_i) begin
      in_reset_q <= reset_i;
      if (reset_i) begin
         strap_q <= {periph_select_n_i, periph_strobe_n_i};
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rom_ans_q <= ANS_IDLE;
         per_ans_q <= ANS_IDLE;
         data_q <= 64'h0000000000000000;
         oe_n_q <= 64'hFFFFFFFFFFFFFFFF;
         dram_q <= DRAM_IDLE;
      end else begin
         rom_ans_q <= rom_ans_d;
         per_ans_q <= per_ans_d;
         data_q <= data_d;
         oe_n_q <= oe_n_d;
         dram_q <= dram_d;
      end
   end

   // dedicated strobes; rom output enable rides the strobe pin
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         feat_q <= 3'h0;
         feat_oe_n_q <= 1'b1;
         rom_ce_n_q <= 1'b1;
         sel_n_q <= 1'b1;
         stb_n_q <= 1'b1;
      end else begin
         feat_q <= pix_i[2:0];
         feat_oe_n_q <= !(feat8_on || pix16_on);
         rom_ce_n_q <= (own_q != OWN_ROM);
         sel_n_q <= (own_q != OWN_PERIPH);
         stb_n_q <= !((own_q == OWN_PERIPH) ||
                      (own_q == OWN_ROM && !rom_q.write));
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign mode_o = mode_q;
   assign mem_grant_o = idle;
   assign rom_ans_o = rom_ans_q;
   assign periph_ans_o = per_ans_q;
   assign memdata_o = data_q;
   assign memdata_oe_n_o = oe_n_q;
   assign feat_low_o = feat_q;
   assign feat_low_oe_n_o = feat_oe_n_q;
   assign dram_o = dram_q;
   assign rom_ce_n_o = rom_ce_n_q;
   // straps are only read while the pins float in reset
   assign periph_select_n_o = sel_n_q;
   assign periph_select_n_oe_n_o = in_reset_q;
   assign periph_strobe_n_o = stb_n_q;
   assign periph_strobe_n_oe_n_o = in_reset_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   logic [7:0] sel_len_q;
   always_ff @(posedge clock_i) begin
      if (reset_i || periph_select_n_o) sel_len_q <= CNT_ZERO;
      else sel_len_q <= sel_len_q + 8'h01;
   end

   sequence s_vga_held;
      mode_o == MODE_VGA && $past(mode_o) == MODE_VGA;
   endsequence
   sequence s_pix_held;
      mode_o == MODE_ACCEL32_PIX && $past(mode_o) == MODE_ACCEL32_PIX;
   endsequence

   a_reset_mode_vga: assert property ($past(reset_i) |->
      mode_o == MODE_VGA) else $error("mode not VGA after reset");
   a_single_pin_owner: assert property (
      rom_ce_n_o || periph_select_n_o) else $error("two pin owners");
   a_periph_fixed_len: assert property (
      $rose(periph_select_n_o) |-> sel_len_q == 8'(PERIPH_CYC))
      else $error("peripheral cycle length wrong");
   a_vga_no_periph: assert property (s_vga_held |->
      periph_select_n_o) else $error("peripheral cycle in VGA mode");
   a_pix_no_rom: assert property (s_pix_held |->
      rom_ce_n_o) else $error("rom cycle in pixel mode");
   a_dram_idle_cycle: assert property (
      (!rom_ce_n_o || !periph_select_n_o) |-> dram_o == DRAM_IDLE)
      else $error("dram pins active in rom or peripheral cycle");
   a_strap_read_bits: assert property (
      rom_ans_o.done && rom_q.sparse |->
      rom_ans_o.rdata[9:8] == strap_q) else $error("strap bits wrong");
   a_feat_pin_order: assert property (
      $past(mode_o == MODE_VGA && pix_valid_i && own_q == OWN_MEM) |->
      memdata_o[63] == $past(pix_i[3]) && memdata_o[59] == $past(pix_i[7]))
      else $error("feature bit order wrong");
   a_rom_refused_pix: assert property (
      idle && rom_req_i.valid && mode_o == MODE_ACCEL32_PIX |=>
      rom_ans_o.refused && own_q == OWN_MEM)
      else $error("rom request not refused");

endmodule

// [testbench/smux_far_side.sv]
// ------------------------------------------------------------------
// far side: boot rom, peripheral, board straps and pin resolution
// ------------------------------------------------------------------
module smux_far_side #(
   parameter logic STRAP_SEL = 1'b1,
   parameter logic STRAP_STB = 1'b0
) (
   input wire logic clock_i,
   input wire logic [63:0] pin_data_i,
   input wire logic [63:0] pin_oe_n_i,
   input wire logic rom_ce_n_i,
   input wire logic sel_i,
   input wire logic sel_oe_n_i,
   input wire logic stb_i,
   input wire logic stb_oe_n_i,
   output logic [63:0] wire_data_o,
   output logic sel_o,
   output logic stb_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pat_q;
   logic [63:0] far_w;
   logic rom_rd_w;
   logic per_rd_w;

   // released lines show a pattern that moves every cycle
   always @(posedge clock_i) begin
      pat_q <= (pat_q === 8'hXX) ? 8'h00 : pat_q + 8'h01;
   end

   // strap resistors hold the level whenever the device floats the pin
   assign sel_o = sel_oe_n_i ? STRAP_SEL : sel_i;
   assign stb_o = stb_oe_n_i ? STRAP_STB : stb_i;
   assign rom_rd_w = !rom_ce_n_i && !stb_o;
   assign per_rd_w = !sel_o && !pin_oe_n_i[26] && !pin_data_i[26];

   // rom and peripheral answer reads with data derived from the address
   always_comb begin
      far_w = {8{pat_q}};
      if (rom_rd_w) begin
         far_w[57:50] = pin_data_i[39:32] ^ 8'h5A;
      end
      if (per_rd_w) begin
         far_w[25:18] = pin_data_i[7:0] ^ 8'hC3;
      end
   end
   assign wire_data_o = (pin_data_i & ~pin_oe_n_i) | (far_w & pin_oe_n_i);
endmodule

// [testbench/smux_shared_pin_mux_test.sv]
module smux_shared_pin_mux_test;
   timeunit 1ns;
   timeprecision 1ps;
   import smux_pkg::*;
   localparam int RC = 4;
   logic clock_i = 1'b0, reset_i = 1'b1, mode_load_i = 1'b0;
   smux_mode_e mode_sel_i = MODE_VGA, mode_o;
   smux_dram_s vga_dram_i = '{9'h1A5, 8'hF0, 3'h6, 1'b0, 1'b1};
   smux_dram_s accel_dram_i = '{9'h05A, 8'h0F, 3'h3, 1'b1, 1'b0};
   smux_dram_s dram_o;
   logic [31:0] vga_wdata_i = 32'h1234ABCD;
   logic [63:0] accel_wdata_i = 64'hF0E1D2C3B4A59687;
   logic vga_wdrive_i = 1'b0, accel_wdrive_i = 1'b0, pix_valid_i = 1'b0;
   logic [15:0] pix_i = 16'h0000;
   smux_rom_req_s rom_req_i = '0;
   smux_periph_req_s periph_req_i = '0;
   smux_ans_s rom_ans_o, periph_ans_o;
   logic [63:0] memdata_i, memdata_o, memdata_oe_n_o;
   logic [2:0] feat_low_o;
   logic mem_grant_o, feat_low_oe_n_o, rom_ce_n_o;
   logic sel_i, sel_o, sel_oe_n, stb_i, stb_o, stb_oe_n;
   int n_fail = 0, checked = 0, cycles = 0;

   always #2.5 clock_i = ~clock_i;

   smux_shared_pin_mux #(.ROM_CYC(RC)) dut (.clock_i(clock_i),
      .reset_i(reset_i), .mode_load_i(mode_load_i), .mode_sel_i(mode_sel_i),
      .mode_o(mode_o), .vga_dram_i(vga_dram_i), .vga_wdata_i(vga_wdata_i),
      .vga_wdrive_i(vga_wdrive_i), .accel_dram_i(accel_dram_i),
      .accel_wdata_i(accel_wdata_i), .accel_wdrive_i(accel_wdrive_i),
      .mem_grant_o(mem_grant_o), .pix_i(pix_i), .pix_valid_i(pix_valid_i),
      .rom_req_i(rom_req_i), .rom_ans_o(rom_ans_o),
      .periph_req_i(periph_req_i), .periph_ans_o(periph_ans_o),
      .memdata_i(memdata_i), .memdata_o(memdata_o),
      .memdata_oe_n_o(memdata_oe_n_o), .feat_low_o(feat_low_o),
      .feat_low_oe_n_o(feat_low_oe_n_o), .dram_o(dram_o),
      .rom_ce_n_o(rom_ce_n_o), .periph_select_n_i(sel_i),
      .periph_select_n_o(sel_o), .periph_select_n_oe_n_o(sel_oe_n),
      .periph_strobe_n_i(stb_i), .periph_strobe_n_o(stb_o),
      .periph_strobe_n_oe_n_o(stb_oe_n));

   smux_far_side #(.STRAP_SEL(1'b1), .STRAP_STB(1'b0)) far (
      .clock_i(clock_i), .pin_data_i(memdata_o),
      .pin_oe_n_i(memdata_oe_n_o), .rom_ce_n_i(rom_ce_n_o), .sel_i(sel_o),
      .sel_oe_n_i(sel_oe_n), .stb_i(stb_o), .stb_oe_n_i(stb_oe_n),
      .wire_data_o(memdata_i), .sel_o(sel_i), .stb_o(stb_i));

   task automatic results();
      if (n_fail == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [63:0] e,
                      input logic [63:0] s);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   // inputs always move a fixed 1 ns after the rising edge
   task automatic tick();
      @(posedge clock_i);
      #1;
   endtask

   task automatic set_mode(input smux_mode_e m);
      mode_sel_i = m;
      mode_load_i = 1'b1;
      tick();
      mode_load_i = 1'b0;
      chk("mode", m, mode_o);
   endtask

   // one rom cycle; valid held until done, then one idle cycle
   task automatic rom_cyc(input logic wr, input logic sp,
      input logic [17:0] a, input logic [7:0] d, output logic [15:0] rd);
      int n = 0;
      rom_req_i = '{1'b1, wr, sp, a, d};
      tick();
      while (n < 40) begin
         tick();
         n++;
         if (n == 2) begin
            chk("rom_ce_n", 0, rom_ce_n_o);
            chk("dram_idle", DRAM_IDLE, dram_o);
            chk("rom_grant", 0, mem_grant_o);
            chk("rom_addr", a, memdata_o[49:32]);
            if (wr) chk("rom_wd", {1'b0, d}, memdata_o[58:50]);
            else chk("rom_oe", 0, stb_o);
         end
         if (rom_ans_o.done === 1'b1) break;
      end
      rd = rom_ans_o.rdata;
      rom_req_i = '0;
      chk("rom_len", RC, n);
      tick();
      chk("rom_back", 1, mem_grant_o);
   endtask

   // one peripheral cycle, fixed length from the package
   task automatic per_cyc(input logic wr, input logic [16:0] a,
      input logic [7:0] d, output logic [15:0] rd);
      int n = 0;
      periph_req_i = '{1'b1, wr, a, d};
      tick();
      while (n < 100) begin
         tick();
         n++;
         if (n == 2) begin
            chk("per_sel", 0, sel_o);
            chk("per_addr", a, memdata_o[16:0]);
            chk("per_rw", {!wr, wr}, memdata_o[27:26]);
            if (wr) chk("per_wd", d, memdata_o[25:18]);
            chk("per_grant", 0, mem_grant_o);
         end
         if (periph_ans_o.done === 1'b1) break;
      end
      rd = periph_ans_o.rdata;
      periph_req_i = '0;
      chk("per_len", PERIPH_CYC, n);
      tick();
   endtask

   // rom and peripheral asked together: rom first, peripheral waits
   task automatic t_contend();
      int n = 0;
      rom_req_i = '{1'b1, 1'b0, 1'b0, 18'h00011, 8'h00};
      periph_req_i = '{1'b1, 1'b0, 17'h00022, 8'h00};
      tick();
      while (n < 200 && periph_ans_o.done !== 1'b1) begin
         if (rom_ans_o.done === 1'b1) begin
            chk("rom_first", RC, n);
            rom_req_i = '0;
         end
         chk("one_owner", 1, rom_ce_n_o | sel_o);
         tick();
         n++;
      end
      periph_req_i = '0;
      chk("wait_len", RC + PERIPH_CYC + 1, n);
      tick();
   endtask

   // request that the mode forbids must come back refused
   task automatic refuse(input logic rom);
      logic seen = 1'b0;
      if (rom) rom_req_i = '{1'b1, 1'b0, 1'b1, 18'h00123, 8'h00};
      else periph_req_i = '{1'b1, 1'b0, 17'h00321, 8'h00};
      repeat (3) begin
         tick();
         if ((rom ? rom_ans_o.refused : periph_ans_o.refused) === 1'b1)
            seen = 1'b1;
         chk("ref_done", 0, rom ? rom_ans_o.done : periph_ans_o.done);
      end
      rom_req_i = '0;
      periph_req_i = '0;
      chk("refused", 1, seen);
      tick();
   endtask

   task automatic t_vga();
      logic [15:0] rd;
      logic [4:0] ex;
      chk("reset_mode", MODE_VGA, mode_o);
      chk("strap_oe", 0, {sel_oe_n, stb_oe_n});
      vga_wdrive_i = 1'b1;
      pix_valid_i = 1'b1;
      pix_i = 16'h00B5;
      tick();
      chk("vga_mem", vga_wdata_i, memdata_o[31:0]);
      chk("vga_oe", 0, memdata_oe_n_o[31:0]);
      chk("vga_dram", vga_dram_i, dram_o);
      for (int k = 0; k < 5; k++) ex[k] = pix_i[7 - k];
      chk("vga_feat", ex, memdata_o[63:59]);
      chk("vga_flow", pix_i[2:0], feat_low_o);
      pix_valid_i = 1'b0;
      vga_wdrive_i = 1'b0;
      rom_cyc(1'b0, 1'b1, 18'h2A5C3, 8'h00, rd);
      chk("rom_rd", {8'h02, 8'hC3 ^ 8'h5A}, rd);
      rom_cyc(1'b0, 1'b0, 18'h00177, 8'h00, rd);
      chk("rom_dense", {8'h00, 8'h77 ^ 8'h5A}, rd);
      refuse(1'b0);
   endtask

   task automatic t_acc64();
      logic [15:0] rd;
      set_mode(MODE_ACCEL64);
      accel_wdrive_i = 1'b1;
      pix_valid_i = 1'b1;
      tick();
      chk("a64_mem", accel_wdata_i, memdata_o);
      chk("a64_oe", 0, memdata_oe_n_o);
      chk("a64_flow", 1, feat_low_oe_n_o);
      chk("a64_dram", accel_dram_i, dram_o);
      pix_valid_i = 1'b0;
      accel_wdrive_i = 1'b0;
      per_cyc(1'b1, 17'h1B2C4, 8'h9E, rd);
      rom_cyc(1'b1, 1'b0, 18'h3FFFF, 8'h6D, rd);
      t_contend();
   endtask

   task automatic t_acc32();
      logic [15:0] rd;
      logic [12:0] ex;
      set_mode(MODE_ACCEL32_ROM);
      accel_wdrive_i = 1'b1;
      tick();
      chk("a32_mem", accel_wdata_i[31:0], memdata_o[31:0]);
      chk("a32_hi", 32'hFFFFFFFF, memdata_oe_n_o[63:32]);
      accel_wdrive_i = 1'b0;
      per_cyc(1'b0, 17'h0A5E1, 8'h00, rd);
      chk("per_rd", 8'hE1 ^ 8'hC3, rd[7:0]);
      rom_cyc(1'b0, 1'b1, 18'h10042, 8'h00, rd);
      chk("a32_rom", {8'h02, 8'h42 ^ 8'h5A}, rd);
      set_mode(MODE_ACCEL32_PIX);
      pix_valid_i = 1'b1;
      pix_i = 16'hB2C5;
      tick();
      for (int k = 0; k < 13; k++) ex[k] = pix_i[15 - k];
      chk("pix_hi", ex, memdata_o[63:51]);
      chk("pix_lo", pix_i[2:0], feat_low_o);
      chk("pix_oe", 0, feat_low_oe_n_o);
      refuse(1'b1);
      per_cyc(1'b1, 17'h00F0F, 8'h3C, rd);
      pix_valid_i = 1'b0;
   endtask

   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         results();
      end
   end

   initial begin
      repeat (6) @(posedge clock_i);
      #1;
      reset_i = 1'b0;
      tick();
      t_vga();
      t_acc64();
      t_acc32();
      results();
   end
endmodule
